//--- src/nvmcs_link_if.sv
`timescale 1ns/1ps
// decoded programming frames between serial link and core
interface nvmcs_link_if;
  logic cmd_valid;
  logic [7:0] cmd;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic rdata_valid;
  logic [7:0] rdata;

  modport link (output cmd_valid, output cmd, output addr, output wdata,
                input rdata_valid, input rdata);
  modport core (input cmd_valid, input cmd, input addr, input wdata,
                output rdata_valid, output rdata);
endinterface

//--- src/nvmcs_pkg.sv
package nvmcs_pkg;

  // ****************************************************************
  // address map
  // ****************************************************************
  localparam logic [15:0] SIG0_ADDR = 16'hfc30;
  localparam logic [15:0] SIG1_ADDR = 16'hfc31;
  localparam logic [15:0] SIG2_ADDR = 16'hfc60;
  localparam logic [15:0] CUST_BASE = 16'hfce0;
  localparam int CUST_ADDR_BITS = 5;
  localparam logic [15:0] CFG1_ADDR = 16'hfd00;
  localparam logic [7:0] CFG1_RESET = 8'hff;

  // ****************************************************************
  // config byte one fields
  // ****************************************************************
  localparam int WDT_EN_BIT = 7;
  localparam int RST_PIN_DIS_BIT = 6;
  localparam logic RST_PIN_DIS_ACTIVE = 1'b1;
  localparam int CLK_SRC_MSB = 2;
  localparam logic [2:0] CLK_EXT = 3'h7;
  localparam logic [2:0] CLK_RC6 = 3'h3;
  localparam logic [2:0] CLK_XTAL_LO = 3'h2;
  localparam logic [2:0] CLK_XTAL_MED = 3'h1;
  localparam logic [2:0] CLK_XTAL_HI = 3'h0;

  // ****************************************************************
  // security states, {bit two, bit one}
  // ****************************************************************
  localparam logic [1:0] SEC_OPEN = 2'h3;
  localparam logic [1:0] SEC_BIT_ONE_ONLY = 2'h2;
  localparam logic [1:0] SEC_BIT_TWO_ONLY = 2'h1;
  localparam logic [1:0] SEC_LOCKED = 2'h0;

  // ****************************************************************
  // serial link frame and commands
  // ****************************************************************
  localparam int FRAME_BITS = 32;
  localparam int READ_BITS = 8;
  localparam logic [7:0] CMD_WRITE = 8'h01;
  localparam logic [7:0] CMD_PROG_BIT_ONE = 8'h02;
  localparam logic [7:0] CMD_PROG_BIT_TWO = 8'h03;
  localparam logic [7:0] CMD_VERIFY = 8'h04;
  localparam logic [7:0] BLOCKED_DATA = 8'h00;

endpackage

//--- src/nvmcs_serial_link.sv
`timescale 1ns/1ps
module nvmcs_serial_link (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic prog_mode,
  input wire logic pgm_clk,
  input wire logic pgm_dat_in,
  output logic pgm_dat_out,
  output logic pgm_dat_oe,
  nvmcs_link_if.link bus
);

  typedef enum logic [1:0] {NVMCS_RX, NVMCS_WAIT_RD, NVMCS_TX} nvmcs_lstate_t;

  nvmcs_lstate_t state_r;
  logic clk_prev_r;
  logic [31:0] shift_r;
  logic [5:0] cnt_r;
  logic [7:0] tx_r;
  logic cmd_valid_r;
  logic [7:0] cmd_r;
  logic [15:0] addr_r;
  logic [7:0] wdata_r;

  // ****************************************************************
  // pin decode
  // ****************************************************************
  wire rise = pgm_clk & ~clk_prev_r;
  wire [31:0] shift_nxt = {shift_r[30:0], pgm_dat_in};
  wire frame_done = rise && (cnt_r == 6'(nvmcs_pkg::FRAME_BITS - 1));
  wire tx_done = rise && (cnt_r == 6'(nvmcs_pkg::READ_BITS - 1));

  assign pgm_dat_oe = (state_r == NVMCS_TX);
  assign pgm_dat_out = tx_r[7];
  assign bus.cmd_valid = cmd_valid_r;
  assign bus.cmd = cmd_r;
  assign bus.addr = addr_r;
  assign bus.wdata = wdata_r;

  // frame shifter: command, address, data in, read byte out, msb first
  always_ff @(posedge mclk) begin
    clk_prev_r <= pgm_clk;
    cmd_valid_r <= 1'b0;
    if (!rstn || !prog_mode) begin
      state_r <= NVMCS_RX;
      cnt_r <= 6'h00;
      shift_r <= 32'h0;
      tx_r <= 8'h00;
    end else begin
      unique case (state_r)
        NVMCS_RX: begin
          if (rise) begin
            shift_r <= shift_nxt;
            cnt_r <= frame_done ? 6'h00 : cnt_r + 6'h01;
          end
          if (frame_done) begin
            cmd_valid_r <= 1'b1;
            if (shift_nxt[31:24] == nvmcs_pkg::CMD_VERIFY) state_r <= NVMCS_WAIT_RD;
          end
        end
        NVMCS_WAIT_RD: begin
          if (bus.rdata_valid) begin
            tx_r <= bus.rdata;
            state_r <= NVMCS_TX;
          end
        end
        NVMCS_TX: begin
          if (rise) begin
            tx_r <= {tx_r[6:0], 1'b0};
            cnt_r <= tx_done ? 6'h00 : cnt_r + 6'h01;
            if (tx_done) state_r <= NVMCS_RX;
          end
        end
      endcase
    end
  end

  // frame fields held until the next frame completes
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cmd_r <= 8'h00;
      addr_r <= 16'h0000;
      wdata_r <= 8'h00;
    end else if (frame_done && state_r == NVMCS_RX && prog_mode) begin
      {cmd_r, addr_r, wdata_r} <= shift_nxt;
    end
  end

  a_link_strobe_single: assert property (@(posedge mclk) disable iff (!rstn)
    cmd_valid_r |=> !cmd_valid_r) else $error("frame strobe longer than one cycle");

  a_link_drive_only_tx: assert property (@(posedge mclk) disable iff (!rstn)
    pgm_dat_oe |-> $past(bus.rdata_valid, 1) || $past(pgm_dat_oe, 1))
    else $error("data pin driven without a read answer");

endmodule // nvmcs_serial_link

//--- src/nvmcs_top.sv
`timescale 1ns/1ps
module nvmcs_top #(
  parameter logic [7:0] SIG0_VAL = 8'h5a, // arbitrary value
  parameter logic [7:0] SIG1_VAL = 8'h3c, // arbitrary value
  parameter logic [7:0] SIG2_VAL = 8'h01  // arbitrary value
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic prog_mode,
  input wire logic pgm_clk,
  input wire logic pgm_dat_in,
  output logic pgm_dat_out,
  output logic pgm_dat_oe,
  input wire logic code_rd_en,
  input wire logic code_fetch,
  input wire logic [15:0] code_rd_addr,
  output logic code_rd_valid,
  output logic [7:0] code_rd_data,
  input wire logic xdata_rd_en,
  input wire logic [15:0] xdata_rd_addr,
  output logic xdata_rd_valid,
  output logic [7:0] xdata_rd_data,
  output logic [15:0] nvm_rd_addr,
  input wire logic [7:0] nvm_rd_data,
  input wire logic [7:0] nvm_cfg1,
  input wire logic [1:0] nvm_sec,
  output logic nvm_wr_en,
  output logic [15:0] nvm_wr_addr,
  output logic [7:0] nvm_wr_data,
  output logic [1:0] nvm_sec_wr,
  output logic prog_reject,
  output logic config_valid,
  output logic watchdog_reset_enable,
  output logic reset_pin_disable,
  output logic [2:0] clock_source_select,
  output logic clock_source_valid
);

  nvmcs_link_if lnk ();

  logic cfg_loaded_r;
  logic [7:0] system_config_byte_one_r;
  logic code_rd_valid_r;
  logic [7:0] code_rd_data_r;
  logic xdata_rd_valid_r;
  logic [7:0] xdata_rd_data_r;
  logic nvm_wr_en_r;
  logic [15:0] nvm_wr_addr_r;
  logic [7:0] nvm_wr_data_r;
  logic [1:0] nvm_sec_wr_r;
  logic prog_reject_r;
  logic rdata_valid_r;
  logic [7:0] rdata_r;

  // ****************************************************************
  // serial programming link
  // ****************************************************************
  nvmcs_serial_link u_link (
    .mclk(mclk),
    .rstn(rstn),
    .prog_mode(prog_mode),
    .pgm_clk(pgm_clk),
    .pgm_dat_in(pgm_dat_in),
    .pgm_dat_out(pgm_dat_out),
    .pgm_dat_oe(pgm_dat_oe),
    .bus(lnk.link)
  );

  // ****************************************************************
  // configuration latch
  // ****************************************************************
  // one capture in the first cycle after power-up reset, then frozen
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cfg_loaded_r <= 1'b0;
      system_config_byte_one_r <= nvmcs_pkg::CFG1_RESET;
    end else if (!cfg_loaded_r) begin
      cfg_loaded_r <= 1'b1;
      system_config_byte_one_r <= nvm_cfg1;
    end
  end

  // field decode of the latched byte
  assign config_valid = cfg_loaded_r;
  assign watchdog_reset_enable = system_config_byte_one_r[nvmcs_pkg::WDT_EN_BIT];
  assign reset_pin_disable = (system_config_byte_one_r[nvmcs_pkg::RST_PIN_DIS_BIT]
                              == nvmcs_pkg::RST_PIN_DIS_ACTIVE);
  assign clock_source_select = system_config_byte_one_r[nvmcs_pkg::CLK_SRC_MSB:0];
  assign clock_source_valid = (clock_source_select == nvmcs_pkg::CLK_EXT)
                           || (clock_source_select == nvmcs_pkg::CLK_RC6)
                           || (clock_source_select == nvmcs_pkg::CLK_XTAL_LO)
                           || (clock_source_select == nvmcs_pkg::CLK_XTAL_MED)
                           || (clock_source_select == nvmcs_pkg::CLK_XTAL_HI);

  // ****************************************************************
  // program-side reads
  // ****************************************************************
  // address decode for identification, customer area and config byte
  wire sig0_hit = (code_rd_addr == nvmcs_pkg::SIG0_ADDR);
  wire sig1_hit = (code_rd_addr == nvmcs_pkg::SIG1_ADDR);
  wire sig2_hit = (code_rd_addr == nvmcs_pkg::SIG2_ADDR);
  wire sig_hit = sig0_hit | sig1_hit | sig2_hit;
  wire cust_hit = (code_rd_addr[15:nvmcs_pkg::CUST_ADDR_BITS]
                   == nvmcs_pkg::CUST_BASE[15:nvmcs_pkg::CUST_ADDR_BITS]);
  wire code_serve = code_rd_en && !prog_mode && !code_fetch && (sig_hit || cust_hit);
  wire [7:0] sig_val = sig0_hit ? SIG0_VAL : (sig1_hit ? SIG1_VAL : SIG2_VAL);
  wire [7:0] code_val = sig_hit ? sig_val : nvm_rd_data;
  wire xdata_serve = xdata_rd_en && !prog_mode && (xdata_rd_addr == nvmcs_pkg::CFG1_ADDR);

  // the array read port follows the programmer while in programming mode
  assign nvm_rd_addr = prog_mode ? lnk.addr : code_rd_addr;

  // registered read answers
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      code_rd_valid_r <= 1'b0;
      code_rd_data_r <= 8'h00;
      xdata_rd_valid_r <= 1'b0;
      xdata_rd_data_r <= 8'h00;
    end else begin
      code_rd_valid_r <= code_serve;
      code_rd_data_r <= code_serve ? code_val : 8'h00;
      xdata_rd_valid_r <= xdata_serve;
      xdata_rd_data_r <= xdata_serve ? system_config_byte_one_r : 8'h00;
    end
  end

  assign code_rd_valid = code_rd_valid_r;
  assign code_rd_data = code_rd_data_r;
  assign xdata_rd_valid = xdata_rd_valid_r;
  assign xdata_rd_data = xdata_rd_data_r;

  // ****************************************************************
  // security gating of programming commands
  // ****************************************************************
  wire cmd_take = lnk.cmd_valid && prog_mode;
  wire is_wr = (lnk.cmd == nvmcs_pkg::CMD_WRITE);
  wire is_prog_one = (lnk.cmd == nvmcs_pkg::CMD_PROG_BIT_ONE);
  wire is_prog_two = (lnk.cmd == nvmcs_pkg::CMD_PROG_BIT_TWO);
  wire is_vfy = (lnk.cmd == nvmcs_pkg::CMD_VERIFY);
  wire sec_open = (nvm_sec == nvmcs_pkg::SEC_OPEN);
  wire sec_one_only = (nvm_sec == nvmcs_pkg::SEC_BIT_ONE_ONLY);
  wire wr_ok = is_wr && sec_open;
  wire one_ok = is_prog_one && sec_open;
  wire two_ok = is_prog_two && (sec_open || sec_one_only);
  wire vfy_ok = is_vfy && (sec_open || sec_one_only);
  wire cmd_ok = wr_ok || one_ok || two_ok || vfy_ok;

  // array write strobes and verify answers
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      nvm_wr_en_r <= 1'b0;
      nvm_wr_addr_r <= 16'h0000;
      nvm_wr_data_r <= 8'h00;
      nvm_sec_wr_r <= 2'h0;
      prog_reject_r <= 1'b0;
      rdata_valid_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      nvm_wr_en_r <= cmd_take && wr_ok;
      if (cmd_take && wr_ok) begin
        nvm_wr_addr_r <= lnk.addr;
        nvm_wr_data_r <= lnk.wdata;
      end
      nvm_sec_wr_r <= {cmd_take && two_ok, cmd_take && one_ok};
      prog_reject_r <= cmd_take && !cmd_ok;
      rdata_valid_r <= cmd_take && is_vfy;
      if (cmd_take && is_vfy) begin
        rdata_r <= vfy_ok ? nvm_rd_data : nvmcs_pkg::BLOCKED_DATA;
      end
    end
  end

  assign lnk.rdata_valid = rdata_valid_r;
  assign lnk.rdata = rdata_r;
  assign nvm_wr_en = nvm_wr_en_r;
  assign nvm_wr_addr = nvm_wr_addr_r;
  assign nvm_wr_data = nvm_wr_data_r;
  assign nvm_sec_wr = nvm_sec_wr_r;
  assign prog_reject = prog_reject_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_cfg_frozen_after: assert property (@(posedge mclk) disable iff (!rstn)
    cfg_loaded_r |=> $stable(system_config_byte_one_r) && cfg_loaded_r)
    else $error("config byte changed after power-up capture");

  a_cfg_capture_once: assert property (@(posedge mclk) disable iff (!rstn)
    !cfg_loaded_r |=> cfg_loaded_r && system_config_byte_one_r == $past(nvm_cfg1))
    else $error("config byte not captured in first cycle");

  a_sig_read_value: assert property (@(posedge mclk) disable iff (!rstn)
    code_rd_en && !prog_mode && !code_fetch && code_rd_addr == nvmcs_pkg::SIG1_ADDR
    |=> code_rd_valid && code_rd_data == SIG1_VAL)
    else $error("identification byte not returned");

  a_cust_read_data: assert property (@(posedge mclk) disable iff (!rstn)
    code_rd_en && !prog_mode && !code_fetch && cust_hit
    |=> code_rd_valid && code_rd_data == $past(nvm_rd_data))
    else $error("customer byte not returned");

  a_cust_no_fetch: assert property (@(posedge mclk) disable iff (!rstn)
    code_fetch |=> !code_rd_valid)
    else $error("fetch served from special region");

  a_xdata_cfg_read: assert property (@(posedge mclk) disable iff (!rstn)
    xdata_serve |=> xdata_rd_valid && xdata_rd_data == $past(system_config_byte_one_r))
    else $error("config byte read mismatch");

  a_wdt_bit_decode: assert property (@(posedge mclk) disable iff (!rstn)
    cfg_loaded_r && !system_config_byte_one_r[7] |-> !watchdog_reset_enable)
    else $error("watchdog reset not disabled");

  a_clk_reserved: assert property (@(posedge mclk) disable iff (!rstn)
    clock_source_select inside {3'h4, 3'h5, 3'h6} |-> !clock_source_valid)
    else $error("reserved clock code flagged valid");

  // latch shows the unprogrammed value until the capture
  a_latch_before_load: assert property (@(posedge mclk) disable iff (!rstn)
    !cfg_loaded_r |-> system_config_byte_one_r == nvmcs_pkg::CFG1_RESET)
    else $error("config latch not at unprogrammed value");

  // reset pin function follows bit 6 of the latched byte
  a_rst_pin_decode: assert property (@(posedge mclk) disable iff (!rstn)
    reset_pin_disable == (system_config_byte_one_r[nvmcs_pkg::RST_PIN_DIS_BIT]
                          == nvmcs_pkg::RST_PIN_DIS_ACTIVE))
    else $error("reset pin disable decode wrong");

  // every documented oscillator code is accepted
  a_clk_known_codes: assert property (@(posedge mclk) disable iff (!rstn)
    clock_source_select inside {3'h7, 3'h3, 3'h2, 3'h1, 3'h0} |-> clock_source_valid)
    else $error("documented clock code flagged reserved");

  // first and third identification bytes
  a_sig_first_byte: assert property (@(posedge mclk) disable iff (!rstn)
    code_rd_en && !prog_mode && !code_fetch && code_rd_addr == nvmcs_pkg::SIG0_ADDR
    |=> code_rd_valid && code_rd_data == SIG0_VAL)
    else $error("first identification byte not returned");

  a_sig_third_byte: assert property (@(posedge mclk) disable iff (!rstn)
    code_rd_en && !prog_mode && !code_fetch && code_rd_addr == nvmcs_pkg::SIG2_ADDR
    |=> code_rd_valid && code_rd_data == SIG2_VAL)
    else $error("third identification byte not returned");

  // programming mode shuts out program-side reads
  a_prog_read_block: assert property (@(posedge mclk) disable iff (!rstn)
    prog_mode |=> !code_rd_valid && !xdata_rd_valid)
    else $error("program read served in programming mode");

  // only the config byte address answers an external-data read
  a_xdata_other_miss: assert property (@(posedge mclk) disable iff (!rstn)
    xdata_rd_en && xdata_rd_addr != nvmcs_pkg::CFG1_ADDR |=> !xdata_rd_valid)
    else $error("external-data read answered off the config address");

  // ****************************************************************
  // security checks
  // ****************************************************************
  // write strobe only from the open state
  a_write_needs_open: assert property (@(posedge mclk) disable iff (!rstn)
    nvm_wr_en |-> $past(nvm_sec) == nvmcs_pkg::SEC_OPEN)
    else $error("array written while secured");

  // bit two stays programmable after bit one
  a_two_after_one: assert property (@(posedge mclk) disable iff (!rstn)
    cmd_take && is_prog_two && sec_one_only |=> nvm_sec_wr == 2'h2 && !prog_reject)
    else $error("bit two refused after bit one");

  a_locked_no_verify: assert property (@(posedge mclk) disable iff (!rstn)
    cmd_take && is_vfy && nvm_sec == nvmcs_pkg::SEC_LOCKED
    |=> lnk.rdata_valid && lnk.rdata == nvmcs_pkg::BLOCKED_DATA && prog_reject)
    else $error("verify not blocked when locked");

  // programming of bit one only from the open state
  a_one_needs_open: assert property (@(posedge mclk) disable iff (!rstn)
    cmd_take && is_prog_one && sec_open |=> nvm_sec_wr == 2'h1 && !prog_reject)
    else $error("bit one not programmed from open state");

  // open state verify returns the array byte
  a_open_verify_data: assert property (@(posedge mclk) disable iff (!rstn)
    cmd_take && is_vfy && sec_open
    |=> lnk.rdata_valid && lnk.rdata == $past(nvm_rd_data) && !prog_reject)
    else $error("verify data not returned while open");

  // any secured state refuses array writes
  a_secured_no_write: assert property (@(posedge mclk) disable iff (!rstn)
    cmd_take && is_wr && !sec_open |=> !nvm_wr_en && prog_reject)
    else $error("array write accepted while secured");

  // fully locked part takes no programming at all
  a_locked_no_prog: assert property (@(posedge mclk) disable iff (!rstn)
    cmd_take && nvm_sec == nvmcs_pkg::SEC_LOCKED
    |=> !nvm_wr_en && nvm_sec_wr == 2'h0 && prog_reject)
    else $error("command accepted while locked");

  // an accepted write carries the frame address and data
  a_write_lands: assert property (@(posedge mclk) disable iff (!rstn)
    cmd_take && wr_ok
    |=> nvm_wr_en && nvm_wr_addr == $past(lnk.addr) && nvm_wr_data == $past(lnk.wdata))
    else $error("array write lost its address or data");

endmodule // nvmcs_top

//--- verification/nvmcs_prog_model.sv
`timescale 1ns/1ps
// programmer on the far side of the two-pin link
module nvmcs_prog_model (
  input wire logic mclk,
  output logic pgm_clk,
  output logic pgm_dat_in,
  input wire logic pgm_dat_out,
  input wire logic pgm_dat_oe
);
  initial begin
    pgm_clk = 1'b0;
    pgm_dat_in = 1'b1;
  end
  // one frame msb first; the clock rests low between frames
  task automatic send(input logic [7:0] cmd, input logic [15:0] addr, input logic [7:0] dat);
    logic [31:0] f;
    f = {cmd, addr, dat};
    for (int i = 31; i >= 0; i--) begin
      @(posedge mclk) #1;
      pgm_clk = 1'b0;
      pgm_dat_in = f[i];
      @(posedge mclk) #1;
      pgm_clk = 1'b1;
    end
    @(posedge mclk) #1;
    pgm_clk = 1'b0;
    pgm_dat_in = ~f[0]; // released line must not show a stale bit
  endtask
  // read phase: take each bit while driven, then clock the next one out
  task automatic recv(output logic [7:0] b, output logic oe_ok);
    oe_ok = 1'b1;
    repeat (4) @(posedge mclk);
    for (int i = 7; i >= 0; i--) begin
      @(posedge mclk) #1;
      b[i] = pgm_dat_out;
      oe_ok &= pgm_dat_oe;
      pgm_clk = 1'b1;
      @(posedge mclk) #1;
      pgm_clk = 1'b0;
      @(posedge mclk);
    end
    repeat (2) @(posedge mclk);
    #1;
    oe_ok &= !pgm_dat_oe;
  endtask
endmodule // nvmcs_prog_model

//--- verification/tb.sv
`timescale 1ns/1ps
module tb;
  logic mclk, rstn, prog_mode, pgm_clk, pgm_dat_in, pgm_dat_out, pgm_dat_oe;
  logic code_rd_en, code_fetch, code_rd_valid, xdata_rd_en, xdata_rd_valid;
  logic [15:0] code_rd_addr, xdata_rd_addr, nvm_rd_addr, nvm_wr_addr;
  logic [7:0] code_rd_data, xdata_rd_data, nvm_rd_data, nvm_cfg1, nvm_wr_data;
  logic [1:0] nvm_sec = 2'h3;
  logic [1:0] nvm_sec_wr;
  logic nvm_wr_en, prog_reject, config_valid, watchdog_reset_enable, reset_pin_disable;
  logic [2:0] clock_source_select;
  logic clock_source_valid;
  logic [7:0] mem [0:65535];
  logic [7:0] cfg, d;
  logic [15:0] sa [3] = '{16'hfc30, 16'hfc31, 16'hfc60};
  logic [7:0] sv [3] = '{8'h96, 8'h69, 8'hc3};
  int bad_count, total_checks, wr_seen, rej_seen, cycles;

  nvmcs_top #(.SIG0_VAL(8'h96), .SIG1_VAL(8'h69), .SIG2_VAL(8'hc3)) nvmcs_top_i (
    .mclk, .rstn, .prog_mode, .pgm_clk, .pgm_dat_in, .pgm_dat_out, .pgm_dat_oe,
    .code_rd_en, .code_fetch, .code_rd_addr, .code_rd_valid, .code_rd_data,
    .xdata_rd_en, .xdata_rd_addr, .xdata_rd_valid, .xdata_rd_data, .nvm_rd_addr,
    .nvm_rd_data, .nvm_cfg1, .nvm_sec, .nvm_wr_en, .nvm_wr_addr, .nvm_wr_data,
    .nvm_sec_wr, .prog_reject, .config_valid, .watchdog_reset_enable,
    .reset_pin_disable, .clock_source_select, .clock_source_valid);
  nvmcs_prog_model nvmcs_prog_model_i (.mclk, .pgm_clk, .pgm_dat_in, .pgm_dat_out,
    .pgm_dat_oe);

  // ****************************************************************
  // clock, array model and timeout
  // ****************************************************************
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  assign nvm_rd_data = mem[nvm_rd_addr];
  // array takes writes, security cells only ever go to 0
  always @(posedge mclk) begin
    cycles++;
    if (nvm_wr_en === 1'b1) begin
      mem[nvm_wr_addr] <= nvm_wr_data;
      wr_seen++;
    end
    if (nvm_sec_wr[0] === 1'b1) nvm_sec[0] <= 1'b0;
    if (nvm_sec_wr[1] === 1'b1) nvm_sec[1] <= 1'b0;
    if (prog_reject === 1'b1) rej_seen++;
    if (cycles > 6000) begin
      bad_count++;
      results();
    end
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic do_reset(input logic [7:0] v);
    rstn = 1'b0;
    nvm_cfg1 = v;
    tick(6);
    rstn = 1'b1;
    tick(2);
  endtask
  // decoded fields against the byte latched at power-up
  task automatic cfg_chk(input logic [7:0] v);
    logic ok;
    ok = (v[2:0] == 3'h7) || (v[2:0] <= 3'h3);
    chk("cfg valid", 16'h1, 16'(config_valid));
    chk("wdt", 16'(v[7]), 16'(watchdog_reset_enable));
    chk("rst pin", 16'(v[6]), 16'(reset_pin_disable));
    chk("clk src", 16'(v[2:0]), 16'(clock_source_select));
    chk("clk ok", 16'(ok), 16'(clock_source_valid));
  endtask
  task automatic xrd(input logic [15:0] a, input logic ev, input logic [7:0] ed);
    xdata_rd_en = 1'b1;
    xdata_rd_addr = a;
    tick(1);
    xdata_rd_en = 1'b0;
    chk("xvalid", 16'(ev), 16'(xdata_rd_valid));
    if (ev) chk("xdata", 16'(ed), 16'(xdata_rd_data));
  endtask
  // back to back: enable stays up, caller lowers it
  task automatic crd(input logic [15:0] a, input logic f, input logic ev, input logic [7:0] ed);
    code_rd_en = 1'b1;
    code_fetch = f;
    code_rd_addr = a;
    tick(1);
    chk("cvalid", 16'(ev), 16'(code_rd_valid));
    chk("cdata", 16'(ed), 16'(code_rd_data));
  endtask
  task automatic link_op(input logic [7:0] c, input logic ew, input logic er,
                         input logic [1:0] es, input logic [7:0] ed);
    int w0, r0;
    logic [7:0] b;
    logic ok;
    w0 = wr_seen;
    r0 = rej_seen;
    nvmcs_prog_model_i.send(c, 16'hfce7, d);
    if (c == 8'h04) begin
      nvmcs_prog_model_i.recv(b, ok);
      chk("verify", 16'(ed), 16'(b));
      chk("oe", 16'h1, 16'(ok));
    end else tick(4);
    chk("writes", 16'(w0 + ew), 16'(wr_seen));
    chk("rejects", 16'(r0 + er), 16'(rej_seen));
    chk("sec", 16'(es), 16'(nvm_sec));
    if (ew) chk("wr addr", 16'hfce7, nvm_wr_addr);
    if (ew) chk("wr data", 16'(d), 16'(nvm_wr_data));
    chk("rd addr", 16'hfce7, nvm_rd_addr);
  endtask
  task automatic results();
    $display("checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {rstn, prog_mode, code_rd_en, code_fetch, xdata_rd_en} = 5'h0;
    code_rd_addr = 16'h0000;
    xdata_rd_addr = 16'h0000;
    nvm_cfg1 = 8'hff;
    void'($urandom(32'h716c4f86));
    for (int i = 0; i < 65536; i++) mem[i] = 8'($urandom);
    do_reset(8'hff);
    cfg_chk(8'hff);
    xrd(16'hfd00, 1'b1, 8'hff);
    for (int c = 0; c < 8; c++) begin
      cfg = (8'($urandom) & 8'hf8) | 8'(c);
      do_reset(cfg);
      cfg_chk(cfg);
      xrd(16'hfd00, 1'b1, cfg);
      nvm_cfg1 = ~cfg;
      tick(3);
      cfg_chk(cfg);
      xrd(16'hfd00, 1'b1, cfg);
    end
    tick(1);
    xrd(16'hfd01, 1'b0, 8'h00);
    $display("test config done");
    for (int i = 0; i < 3; i++) crd(sa[i], 1'b0, 1'b1, sv[i]);
    for (int i = 0; i < 32; i++) crd(16'hfce0 + 16'(i), 1'b0, 1'b1, mem[16'hfce0 + i]);
    crd(16'hfcdf, 1'b0, 1'b0, 8'h00);
    crd(16'hfd00, 1'b0, 1'b0, 8'h00);
    crd(16'hfc32, 1'b0, 1'b0, 8'h00);
    crd(16'hfce0, 1'b1, 1'b0, 8'h00);
    code_rd_en = 1'b0;
    $display("test code space done");
    prog_mode = 1'b1;
    tick(2);
    d = 8'($urandom);
    link_op(8'h01, 1'b1, 1'b0, 2'h3, 8'h00);
    link_op(8'h04, 1'b0, 1'b0, 2'h3, d);
    link_op(8'h55, 1'b0, 1'b1, 2'h3, 8'h00);
    link_op(8'h02, 1'b0, 1'b0, 2'h2, 8'h00);
    link_op(8'h01, 1'b0, 1'b1, 2'h2, 8'h00);
    link_op(8'h04, 1'b0, 1'b0, 2'h2, d);
    link_op(8'h03, 1'b0, 1'b0, 2'h0, 8'h00);
    link_op(8'h04, 1'b0, 1'b1, 2'h0, 8'h00);
    link_op(8'h01, 1'b0, 1'b1, 2'h0, 8'h00);
    crd(16'hfce7, 1'b0, 1'b0, 8'h00);
    prog_mode = 1'b0;
    crd(16'hfce7, 1'b1, 1'b0, 8'h00);
    crd(16'hfce7, 1'b0, 1'b1, d);
    code_rd_en = 1'b0;
    $display("test link and security done");
    results();
  end
endmodule // tb
